// file: logic/rsl_cfg.svh
// Behaviour
// RULE1: The serial port works only as a three-wire bus master.
// RULE2: Radio select comes from a general port pin, not the master.
// RULE3: Master data out comes from the shift register MSB, MSB first.
// RULE4: Slave data out is MSB first and released when disabled.
// RULE5: The master makes the serial clock; the slave only receives it.
// RULE6: Master enable bit selects master mode; only the master starts transfers.
// RULE7: Data write loads transmit buffer; empty shifter takes it and starts shifting.
// RULE8: Transfer done flag sets after each byte and raises enabled interrupt.
// RULE9: Master shifts slave data in MSB first; full byte goes to receive buffer.
// RULE10: A transaction is select bit, 7-bit index, then 8-bit data.
// RULE11: Select bit 1 means write, 0 means read.
// RULE12: The index picks one of 128 eight-bit slave registers.
// RULE13: Slave captures index or data once per eight serial clocks.
// RULE14: Serial clock to the radio stays at or below 10 MHz.
// RULE15: On a read the slave ignores the eight bits after the index.
// RULE16: On a read the slave shifts data out on eight falling edges.
// RULE17: After a read slave output holds last bit; pulled high when deselected. The closing fall drives the next register's top bit instead.
// RULE18: Burst: while selected, index increments for every further eight clocks.
// RULE19: Serial interrupt goes to the processor; radio interrupt stays independent.
// RULE20: Master runs clock polarity 0 and clock phase 0.
// RULE21: Bit rate at most half system clock and at most 12.5 MHz.
// RULE22: Master samples incoming data one system clock before bit end.
// RULE23: Data write during a transfer is dropped and sets collision flag.
// RULE24: Controller holds select low for all bytes, then releases it high.
// RULE25: Only software clears the transfer done flag.
`ifndef RSL_CFG_SVH
`define RSL_CFG_SVH
`define RSL_REF_KHZ      200000
`define RSL_MAX_BIT_KHZ  12500
`define RSL_MIN_HALF     ((`RSL_REF_KHZ + 2 * `RSL_MAX_BIT_KHZ - 1) / (2 * `RSL_MAX_BIT_KHZ))
`define RSL_DIV_W        8
`define RSL_LAST_BIT     3'h7
`define RSL_FIRST_BIT    3'h0
`define RSL_NREGS        128
`define RSL_IDX_W        7
`define RSL_SEL_WRITE    1'b1
`define RSL_BYTE_RST     8'h00
`endif

// file: logic/rsl_pkg.sv
package rsl_pkg;
    typedef enum logic [2:0]
    {
        RSL_IDLE = 3'b001,
        RSL_LOW  = 3'b010,
        RSL_HIGH = 3'b100
    } rsl_mst_e;
endpackage : rsl_pkg

// file: logic/rsl_top.sv
`timescale 1ns/1ps
`include "rsl_cfg.svh"
module rsl_top
    import rsl_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        MASTER_EN,
    input  wire logic [7:0]  CLK_DIV,
    input  wire logic        IRQ_EN,
    input  wire logic        DATA_WR,
    input  wire logic [7:0]  DATA_WDATA,
    input  wire logic        DONE_CLR,
    input  wire logic        COLL_CLR,
    output logic [7:0]       RX_DATA,
    output logic             DONE_FLAG,
    output logic             COLL_FLAG,
    output logic             BUSY,
    output logic             TX_FULL,
    output logic             SERIAL_IRQ,
    output logic             SCK_O,
    output logic             MOSI_O,
    input  wire logic        MISO_I,
    input  wire logic        SLV_EN,
    input  wire logic        SLV_SCK_I,
    input  wire logic        SLV_MOSI_I,
    input  wire logic        SLV_NSS_N_I,
    output logic             MISO_O,
    output logic             MISO_OE,
    output logic             RADIO_WSTB,
    output logic [6:0]       RADIO_WADDR,
    output logic [7:0]       RADIO_WDATA
);

    rsl_mst_e    st_q;
    logic [7:0]  tx_buf_q;
    logic        tx_full_q;
    logic        busy_q;
    logic [7:0]  sh_q;
    logic [7:0]  rx_q;
    logic [2:0]  bit_q;
    logic [7:0]  cnt_q;
    logic [7:0]  half;
    logic        sck_q;
    logic        done_q;
    logic        coll_q;
    logic        irq_q;
    logic        miso_s1_q;
    logic        miso_s2_q;
    logic        done_set;
    logic        coll_set;
    logic        start;

    // Clamp keeps bit rate legal even if software programs zero
    assign half = (CLK_DIV < 8'(`RSL_MIN_HALF)) ? 8'(`RSL_MIN_HALF) : CLK_DIV; // RULE21

    // Collision checks busy too, since the buffer drains the same cycle
    assign coll_set = DATA_WR && (busy_q || tx_full_q); // RULE23
    assign start    = tx_full_q && !busy_q && MASTER_EN; // RULE6

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else
        begin
            miso_s1_q <= MISO_I;
            miso_s2_q <= miso_s1_q;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            tx_buf_q  <= `RSL_BYTE_RST;
            tx_full_q <= 1'b0;
        end
        else if (DATA_WR && !coll_set)
        begin
            tx_buf_q  <= DATA_WDATA; // RULE7
            tx_full_q <= 1'b1;
        end
        else if (start)
        begin
            tx_full_q <= 1'b0;
        end
    end

    // Mode 0 only: clock idles low, data set up before the rising edge
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            st_q   <= RSL_IDLE;
            busy_q <= 1'b0;
            sh_q   <= `RSL_BYTE_RST;
            rx_q   <= `RSL_BYTE_RST;
            bit_q  <= `RSL_FIRST_BIT;
            cnt_q  <= 8'h00;
            sck_q  <= 1'b0;
        end
        else
        begin
            case (st_q)
                RSL_IDLE:
                begin
                    sck_q <= 1'b0; // RULE20
                    if (start)
                    begin
                        sh_q   <= tx_buf_q; // RULE7
                        busy_q <= 1'b1;
                        bit_q  <= `RSL_FIRST_BIT;
                        cnt_q  <= 8'(half - 8'h01);
                        st_q   <= RSL_LOW;
                    end
                end
                RSL_LOW:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        sck_q <= 1'b1; // RULE5
                        cnt_q <= 8'(half - 8'h01);
                        st_q  <= RSL_HIGH;
                    end
                    else
                    begin
                        cnt_q <= 8'(cnt_q - 8'h01);
                    end
                end
                RSL_HIGH:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        // Last cycle of the bit: sample then shift
                        sh_q  <= {sh_q[6:0], miso_s2_q}; // RULE22 RULE9
                        sck_q <= 1'b0;
                        cnt_q <= 8'(half - 8'h01);
                        if (bit_q == `RSL_LAST_BIT)
                        begin
                            rx_q   <= {sh_q[6:0], miso_s2_q}; // RULE9
                            busy_q <= 1'b0;
                            st_q   <= RSL_IDLE;
                        end
                        else
                        begin
                            bit_q <= 3'(bit_q + 3'h1);
                            st_q  <= RSL_LOW;
                        end
                    end
                    else
                    begin
                        cnt_q <= 8'(cnt_q - 8'h01);
                    end
                end
                default:
                begin
                    st_q   <= RSL_IDLE;
                    busy_q <= 1'b0;
                    sck_q  <= 1'b0;
                end
            endcase
        end
    end

    assign done_set = (st_q == RSL_HIGH) && (cnt_q == 8'h00) && (bit_q == `RSL_LAST_BIT);

    // Set beats clear so a byte ending on a clear is not lost
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            done_q <= 1'b0;
            coll_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            done_q <= done_set || (done_q && !DONE_CLR); // RULE8 RULE25
            coll_q <= coll_set || (coll_q && !COLL_CLR); // RULE23
            irq_q  <= IRQ_EN && (done_q || coll_q); // RULE8 RULE19
        end
    end

    assign RX_DATA    = rx_q;
    assign DONE_FLAG  = done_q;
    assign COLL_FLAG  = coll_q;
    assign BUSY       = busy_q;
    assign TX_FULL    = tx_full_q;
    assign SERIAL_IRQ = irq_q;
    assign SCK_O      = sck_q;
    assign MOSI_O     = sh_q[7]; // RULE3 RULE1

    // Radio-side slave: select arrives from a port pin outside this block
    logic [2:0]  sck_sy_q;
    logic [1:0]  mosi_sy_q;
    logic [1:0]  nss_sy_q;
    logic        sck_rise;
    logic        sck_fall;
    logic        nss_n;
    logic [2:0]  bc_q;
    logic        hdr_q;
    logic        rw_q;
    logic [6:0]  addr_q;
    logic [7:0]  in_sh_q;
    logic [7:0]  out_sh_q;
    logic        miso_q;
    logic        oe_q;
    logic        wstb_q;
    logic [6:0]  waddr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  regs_q [`RSL_NREGS];
    logic [7:0]  in_byte;
    logic        byte_end;

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            sck_sy_q  <= 3'h0;
            mosi_sy_q <= 2'h0;
            nss_sy_q  <= 2'h3;
        end
        else
        begin
            sck_sy_q  <= {sck_sy_q[1:0], SLV_SCK_I};
            mosi_sy_q <= {mosi_sy_q[0], SLV_MOSI_I};
            nss_sy_q  <= {nss_sy_q[0], SLV_NSS_N_I}; // RULE2
        end
    end

    assign nss_n    = nss_sy_q[1];
    assign sck_rise = !nss_n && sck_sy_q[1] && !sck_sy_q[2];
    assign sck_fall = !nss_n && !sck_sy_q[1] && sck_sy_q[2];
    assign in_byte  = {in_sh_q[6:0], mosi_sy_q[1]};
    assign byte_end = sck_rise && (bc_q == `RSL_LAST_BIT);

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST || nss_n)
        begin
            bc_q    <= `RSL_FIRST_BIT;
            hdr_q   <= 1'b0;
            rw_q    <= 1'b0;
            addr_q  <= 7'h00;
            in_sh_q <= `RSL_BYTE_RST;
        end
        else if (sck_rise)
        begin
            in_sh_q <= in_byte;
            bc_q    <= 3'(bc_q + 3'h1);
            if (byte_end && !hdr_q)
            begin
                // Select bit first, then seven index bits
                rw_q   <= in_byte[7]; // RULE10 RULE11 RULE13
                addr_q <= in_byte[6:0]; // RULE12
                hdr_q  <= 1'b1;
            end
            else if (byte_end)
            begin
                addr_q <= 7'(addr_q + 7'h01); // RULE18
            end
        end
    end

    // Write strobe: data bits after the index are dropped on reads
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            wstb_q  <= 1'b0;
            waddr_q <= 7'h00;
            wdata_q <= `RSL_BYTE_RST;
        end
        else
        begin
            wstb_q <= byte_end && hdr_q && (rw_q == `RSL_SEL_WRITE); // RULE15 RULE11
            if (byte_end && hdr_q)
            begin
                waddr_q <= addr_q;
                wdata_q <= in_byte; // RULE13
            end
        end
    end

    generate
        for (genvar i = 0; i < `RSL_NREGS; i++)
        begin : g_reg
            always_ff @(posedge REF_CLK)
            begin
                if (!NRST)
                begin
                    regs_q[i] <= `RSL_BYTE_RST;
                end
                else if (byte_end && hdr_q && (rw_q == `RSL_SEL_WRITE) && (addr_q == i))
                begin
                    regs_q[i] <= in_byte; // RULE12 RULE18
                end
            end
        end
    endgenerate

    // Output path: load on index or byte end, shift on falling edges
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            out_sh_q <= `RSL_BYTE_RST;
            miso_q   <= 1'b1;
            oe_q     <= 1'b0;
        end
        else
        begin
            oe_q <= SLV_EN; // RULE4
            if (nss_n)
            begin
                miso_q <= 1'b1; // RULE17
            end
            else if (byte_end && !hdr_q)
            begin
                out_sh_q <= regs_q[in_byte[6:0]]; // RULE16
            end
            else if (byte_end)
            begin
                out_sh_q <= regs_q[7'(addr_q + 7'h01)]; // RULE18
            end
            else if (sck_fall && hdr_q && (rw_q != `RSL_SEL_WRITE))
            begin
                miso_q   <= out_sh_q[7]; // RULE16 RULE4
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    assign MISO_O      = miso_q;
    assign MISO_OE     = oe_q;
    assign RADIO_WSTB  = wstb_q;
    assign RADIO_WADDR = waddr_q;
    assign RADIO_WDATA = wdata_q;

    // Helper: length of each clock high phase
    logic [7:0] hi_len_q;
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            hi_len_q <= 8'h00;
        end
        else
        begin
            hi_len_q <= sck_q ? 8'(hi_len_q + 8'h01) : 8'h00;
        end
    end

    a_done_sticky: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE25
        done_q && !DONE_CLR |=> done_q)
        else $error("done flag dropped without clear");
    a_done_end: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE8
        $fell(busy_q) |-> done_q)
        else $error("byte ended without done flag");
    a_coll_set: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE23
        DATA_WR && busy_q |=> coll_q && $stable(tx_buf_q))
        else $error("write during transfer not flagged");
    a_start_load: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE7
        start |=> busy_q && (sh_q == $past(tx_buf_q)) && !sck_q)
        else $error("buffer not moved to shifter");
    a_no_start_off: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE6
        !busy_q && !MASTER_EN |=> !busy_q)
        else $error("transfer started without master enable");
    a_half_min: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE21
        $fell(sck_q) |-> hi_len_q >= 8'(`RSL_MIN_HALF))
        else $error("clock high phase too short");
    a_idle_low: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE20
        !busy_q |-> !sck_q)
        else $error("clock not low when idle");
    a_irq_gate: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE8
        done_q && IRQ_EN |=> irq_q)
        else $error("enabled interrupt missing");
    a_miso_release: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE4
        !SLV_EN |=> !oe_q)
        else $error("slave output driven while disabled");
    a_miso_pullup: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE17
        nss_n |=> miso_q)
        else $error("slave output not high when deselected");
    a_reg_write: assert property (@(posedge REF_CLK) disable iff (!NRST) // RULE12
        wstb_q |-> regs_q[waddr_q] == wdata_q)
        else $error("register write lost");

    c_write_txn: cover property (@(posedge REF_CLK) disable iff (!NRST) wstb_q);
    c_read_txn: cover property (@(posedge REF_CLK) disable iff (!NRST)
        byte_end && hdr_q && !rw_q);
    c_burst: cover property (@(posedge REF_CLK) disable iff (!NRST)
        wstb_q ##[1:1000] wstb_q);
    c_collision: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(coll_q));

endmodule : rsl_top

// file: tb/rsl_radio_model.sv
`timescale 1ns/1ps
module rsl_radio_model
(
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic nss_n,
    output logic      miso
);
    logic [7:0] mem [0:127];
    logic [7:0] sh;
    logic [6:0] idx;
    logic       wr;
    int         cnt;

    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        cnt = 0;
        wr = 1'h0;
        miso = 1'h1;
    end

    always @(negedge nss_n)
        cnt = 0;

    // Released line shows the pull-up level
    always @(posedge nss_n)
        miso = 1'h1;

    // Clock only received, never made here
    always @(posedge sck)
    begin
        if (!nss_n)
        begin
            sh = {sh[6:0], mosi};
            cnt++;
            if (cnt == 8)
            begin
                wr = sh[7];
                idx = sh[6:0];
            end
            else if (cnt % 8 == 0)
            begin
                if (wr)
                    mem[idx] = sh;
                idx++;
            end
        end
    end

    always @(negedge sck)
        if (!nss_n && cnt >= 8 && !wr)
            miso = mem[idx][7 - ((cnt - 8) % 8)];
endmodule : rsl_radio_model

// file: tb/radio_spi_master_link_bench.sv
`timescale 1ns/1ps
`include "rsl_cfg.svh"
module radio_spi_master_link_bench;
    logic        REF_CLK, NRST, MASTER_EN, IRQ_EN, DATA_WR, DONE_CLR, COLL_CLR, MISO_I;
    logic        DONE_FLAG, COLL_FLAG, BUSY, TX_FULL, SERIAL_IRQ, SCK_O, MOSI_O, nss_n;
    logic        SLV_EN, SLV_SCK_I, SLV_MOSI_I, SLV_NSS_N_I, MISO_O, MISO_OE, RADIO_WSTB;
    logic [7:0]  CLK_DIV, DATA_WDATA, RX_DATA, RADIO_WDATA, rx, d;
    logic [6:0]  RADIO_WADDR, idx;
    logic [31:0] got;
    logic [14:0] wq [$];
    logic [7:0]  rmem [0:127];
    logic [7:0]  smem [0:127];
    int          failures, num_checks, seed, lat;

    rsl_top i_dut
    (
        .REF_CLK(REF_CLK), .NRST(NRST), .MASTER_EN(MASTER_EN), .CLK_DIV(CLK_DIV),
        .IRQ_EN(IRQ_EN), .DATA_WR(DATA_WR), .DATA_WDATA(DATA_WDATA), .DONE_CLR(DONE_CLR),
        .COLL_CLR(COLL_CLR), .RX_DATA(RX_DATA), .DONE_FLAG(DONE_FLAG), .COLL_FLAG(COLL_FLAG),
        .BUSY(BUSY), .TX_FULL(TX_FULL), .SERIAL_IRQ(SERIAL_IRQ), .SCK_O(SCK_O),
        .MOSI_O(MOSI_O), .MISO_I(MISO_I), .SLV_EN(SLV_EN), .SLV_SCK_I(SLV_SCK_I),
        .SLV_MOSI_I(SLV_MOSI_I), .SLV_NSS_N_I(SLV_NSS_N_I), .MISO_O(MISO_O),
        .MISO_OE(MISO_OE), .RADIO_WSTB(RADIO_WSTB), .RADIO_WADDR(RADIO_WADDR),
        .RADIO_WDATA(RADIO_WDATA)
    );

    rsl_radio_model i_radio (.sck(SCK_O), .mosi(MOSI_O), .nss_n(nss_n), .miso(MISO_I));

    initial
    begin
        REF_CLK = 1'h0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_data

    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bit

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge REF_CLK);
            #1;
        end
    endtask : ticks

    // Below the floor the divider is clamped, so expectations clamp too
    function automatic int half_of(input logic [7:0] dv);
        return (dv < `RSL_MIN_HALF) ? `RSL_MIN_HALF : int'(dv);
    endfunction : half_of

    // One master byte; coll adds a refused write in the buffer window
    task automatic mbyte(input logic [7:0] tx, input logic coll);
        DATA_WDATA = tx;
        DATA_WR = 1'h1;
        ticks(1);
        chk_bit(TX_FULL, 1'h1);
        DATA_WR = coll;
        DATA_WDATA = ~tx;
        ticks(1);
        DATA_WR = 1'h0;
        chk_bit(BUSY, 1'h1);
        chk_bit(COLL_FLAG, coll);
        lat = 2;
        // Clear, then refuse a write mid-shift, so the busy case shows alone
        while (DONE_FLAG !== 1'h1 && lat < 5000)
        begin
            COLL_CLR = coll && (lat == 3);
            DATA_WR = coll && (lat == 5);
            ticks(1);
            lat++;
        end
        chk_data(lat, 16 * half_of(CLK_DIV) + 2);
        chk_bit(COLL_FLAG, coll);
        chk_bit(BUSY, 1'h0);
        rx = RX_DATA;
        ticks(1);
        chk_bit(SERIAL_IRQ, IRQ_EN);
        chk_bit(DONE_FLAG, 1'h1);
        DONE_CLR = 1'h1;
        COLL_CLR = 1'h1;
        ticks(1);
        DONE_CLR = 1'h0;
        COLL_CLR = 1'h0;
        ticks(1);
        chk_bit(DONE_FLAG | COLL_FLAG, 1'h0);
    endtask : mbyte

    task automatic radio(input logic w, input logic [6:0] a, input logic [7:0] v,
                         input logic c);
        nss_n = 1'h0;
        ticks(1);
        mbyte({w, a}, c);
        mbyte(v, 1'h0);
        nss_n = 1'h1;
        ticks(20);
    endtask : radio

    // Link clock at 48 ns, still between frames
    task automatic sxfer(input logic [31:0] b);
        ticks(1);
        SLV_NSS_N_I = 1'h0;
        got = 32'h0;
        #24;
        for (int i = 31; i >= 0; i--)
        begin
            SLV_MOSI_I = b[i];
            #24 SLV_SCK_I = 1'h1;
            got = {got[30:0], MISO_O};
            #24 SLV_SCK_I = 1'h0;
        end
        SLV_MOSI_I = ~SLV_MOSI_I;
        #60;
    endtask : sxfer

    always @(negedge REF_CLK)
        if (NRST === 1'h1 && RADIO_WSTB === 1'h1)
            chk_data({RADIO_WADDR, RADIO_WDATA}, wq.size() ? wq.pop_front() : 32'hFFFF);

    initial
    begin
        #400000;
        failures++;
        test_done();
    end

    initial
    begin
        seed = 32'h8B8C22B3;
        {MASTER_EN, IRQ_EN, DATA_WR, DONE_CLR, COLL_CLR, SLV_EN, SLV_SCK_I, SLV_MOSI_I} = '0;
        {NRST, nss_n, SLV_NSS_N_I, CLK_DIV, DATA_WDATA} = {3'h3, 8'h0A, 8'h00};
        for (int i = 0; i < 128; i++)
            {rmem[i], smem[i]} = 16'h0;
        ticks(3);
        NRST = 1'h1;
        chk_bit(SCK_O, 1'h0);
        chk_bit(MISO_O, 1'h1);
        chk_bit(MISO_OE, 1'h0);
        MASTER_EN = 1'h1;
        for (int i = 0; i < 6; i++)
        begin
            idx = $random(seed);
            d = $random(seed);
            IRQ_EN = i[0];
            // Slower divider on odd passes; the radio never sees above 10 MHz
            CLK_DIV = i[0] ? 8'h0C : 8'h0A;
            radio(1'h1, idx, d, i == 1);
            rmem[idx] = d;
            radio(1'h0, idx, ~d, 1'h0);
            chk_data(rx, rmem[idx]);
        end
        // Clamped rate only with the radio deselected: pull-up reads as ones
        CLK_DIV = 8'h03;
        mbyte(8'h5A, 1'h0);
        chk_data(rx, 32'hFF);
        MASTER_EN = 1'h0;
        DATA_WR = 1'h1;
        ticks(1);
        DATA_WR = 1'h0;
        repeat (40)
        begin
            ticks(1);
            chk_bit(BUSY | SCK_O, 1'h0);
        end
        NRST = 1'h0;
        ticks(3);
        NRST = 1'h1;
        chk_bit(TX_FULL | BUSY | DONE_FLAG, 1'h0);
        SLV_EN = 1'h1;
        ticks(2);
        chk_bit(MISO_OE, 1'h1);
        for (int k = 0; k < 4; k++)
        begin
            // Bursts kept below the top of the map
            idx = 7'($random(seed)) & 7'h7C;
            d = $random(seed);
            for (int j = 0; j < 3; j++)
            begin
                smem[idx + j] = d + 8'(j * 8'h3B);
                wq.push_back({idx + 7'(j), smem[idx + j]});
            end
            sxfer({1'h1, idx, smem[idx], smem[idx + 1], smem[idx + 2]});
            SLV_NSS_N_I = 1'h1;
            #100;
            sxfer({1'h0, idx, ~d, d, ~d});
            chk_data(got[23:0], {smem[idx], smem[idx + 1], smem[idx + 2]});
            // Last fall of a burst already shows the next register's top bit
            chk_bit(MISO_O, smem[idx + 3][7]);
            SLV_NSS_N_I = 1'h1;
            #100;
            chk_bit(MISO_O, 1'h1);
        end
        SLV_EN = 1'h0;
        ticks(2);
        chk_bit(MISO_OE, 1'h0);
        chk_data(wq.size(), 32'h0);
        test_done();
    end
endmodule : radio_spi_master_link_bench
